// File: pkg/mpe_pkg.sv
`default_nettype none
package mpe_pkg;
	localparam int unsigned CLK_NS = 50;
	localparam int unsigned MAX_DIES = 4;
	localparam int unsigned T_START_NS = 200000;
	localparam int unsigned START_CYC = (T_START_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned T_OE_NS = 25000;
	localparam int unsigned OE_CYC = T_OE_NS / CLK_NS;
	localparam int unsigned T_GATE_NS = 700;
	localparam int unsigned GATE_CYC = (T_GATE_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned T_RISE_NS = 1000;
	localparam int unsigned RISE_CYC = (T_RISE_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned ACCESS_CODE_WAIT_LIMIT_MIN_NS = 1400;
	localparam int unsigned MSGRX_MIN_CYC =
		(ACCESS_CODE_WAIT_LIMIT_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned ACCESS_CODE_WAIT_LIMIT_MAX_NS = 300000;
	localparam int unsigned MSGRX_MAX_CYC = ACCESS_CODE_WAIT_LIMIT_MAX_NS / CLK_NS;
	localparam int unsigned T_WRITE_NS = 20000000;
	localparam int unsigned WRITE_CYC = T_WRITE_NS / CLK_NS;
	localparam int unsigned T_ACC_NS = 500000000;
	localparam int unsigned ACC_CYC = T_ACC_NS / CLK_NS;
	localparam int unsigned PRE_LOW_BITS = 2;
	localparam int unsigned RESP_BITS = 37;
	localparam int unsigned CMD_BITS = 49;
	localparam int unsigned RX_BITS = 36;
	localparam int unsigned PWM_HOLD_PER = 2;
	localparam int unsigned SENT_HOLD = 30;
	localparam int unsigned SPS_SHORT_MIN = 50;
	localparam int unsigned SPS_SHORT_MAX = 83;
	localparam int unsigned SPS_LONG_MIN = 196;
	localparam int unsigned SPS_LONG_MAX = 297;
	localparam int unsigned APS_MIN = 50;
	localparam int unsigned APS_MAX = 80;
	localparam int unsigned NO_MAX = 511;

	typedef enum logic [2:0] {
		OM_PWM, OM_SENT, OM_TRIG_SENT, OM_SPS_SHORT, OM_SPS_LONG, OM_APS
	} mpe_mode_t;

	typedef enum logic [1:0] {
		CMD_WR_ACCESS, CMD_WR_EEPROM, CMD_WR_VOLATILE, CMD_READ
	} mpe_cmd_t;

	function automatic logic [8:0] hold_min(mpe_mode_t m);
		case (m)
			OM_PWM: return 9'(PWM_HOLD_PER);
			OM_SENT, OM_TRIG_SENT: return 9'(SENT_HOLD);
			OM_SPS_SHORT: return 9'(SPS_SHORT_MIN);
			OM_SPS_LONG: return 9'(SPS_LONG_MIN);
			OM_APS: return 9'(APS_MIN);
			default: return 9'(NO_MAX);
		endcase
	endfunction

	function automatic logic [8:0] hold_max(mpe_mode_t m);
		case (m)
			OM_SPS_SHORT: return 9'(SPS_SHORT_MAX);
			OM_SPS_LONG: return 9'(SPS_LONG_MAX);
			OM_APS: return 9'(APS_MAX);
			default: return 9'(NO_MAX);
		endcase
	endfunction
endpackage
`default_nettype wire

// File: pkg/mpe_if.sv
`timescale 1ns/10ps
`default_nettype none
interface mpe_if;
	logic                          program_enable;
	logic                          host_out;
	logic                          host_oe;
	wire [mpe_pkg::MAX_DIES-1:0]   dev_out;
	wire [mpe_pkg::MAX_DIES-1:0]   dev_oe;
	logic                          line;

	// Open-drain wire with pull-up: any enabled low driver wins
	assign line = ~((host_oe & ~host_out) | (|(dev_oe & ~dev_out)));

	modport dev (
		input  program_enable,
		input  line,
		output dev_out,
		output dev_oe
	);
	modport host (
		output program_enable,
		output host_out,
		output host_oe,
		input  line
	);
endinterface
`default_nettype wire

// File: src/mpe_sync.sv
`timescale 1ns/10ps
`default_nettype none
module mpe_sync #(
	parameter logic INIT = 1'b1
) (
	input  wire logic clk,
	input  wire logic srst,
	input  wire logic din,
	output var  logic dout
);
	typedef struct packed {
		logic [2:0] sr;
		logic       o;
	} mpe_sync_t;

	mpe_sync_t s_q;
	mpe_sync_t s_d;

	always_comb begin
		s_d = s_q;
		s_d.sr = {s_q.sr[1:0], din};
		// Only the last two stages vote, the first is metastable
		if (s_q.sr[1] == s_q.sr[2]) begin
			s_d.o = s_q.sr[2];
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s_q <= '{sr: {3{INIT}}, o: INIT};
		end else begin
			s_q <= s_d;
		end
	end

	assign dout = s_q.o;
endmodule // mpe_sync
`default_nettype wire

// File: src/mpe_host.sv
`timescale 1ns/10ps
`default_nettype none
module mpe_host (
	input  wire logic              clk,
	input  wire logic              srst,
	mpe_if.host                    lnk,
	input  wire mpe_pkg::mpe_mode_t mode,
	input  wire logic [15:0]       unit_cyc,
	input  wire logic [15:0]       half_cyc,
	input  wire logic              frame_window,
	input  wire logic              go_3w,
	input  wire logic              go_aux,
	input  wire logic              send,
	input  wire mpe_pkg::mpe_cmd_t kind,
	input  wire logic [48:0]       frame,
	input  wire logic [5:0]        frame_len,
	input  wire logic              end_prog,
	output var  logic              ready,
	output var  logic              rx_valid,
	output var  logic [35:0]       rx_word
);
	typedef enum logic [8:0] {
		H_IDLE = 9'h001, H_PRE = 9'h002, H_WIN = 9'h004,
		H_HOLD = 9'h008, H_REL = 9'h010, H_GATE = 9'h020,
		H_TX = 9'h040, H_RX = 9'h080, H_RDY = 9'h100
	} mpe_hst_t;

	typedef struct packed {
		mpe_hst_t    st;
		logic [19:0] cnt;
		logic [15:0] pre;
		logic [8:0]  units;
		logic [48:0] sh;
		logic [5:0]  len;
		logic [6:0]  nb;
		logic        rd;
		logic        pe;
		logic        oe;
		logic        rdy;
		logic        rx_v;
		logic [35:0] rx_w;
		logic        lv;
	} mpe_hstate_t;

	localparam mpe_hstate_t H_RST = '{st: H_IDLE, lv: 1'b1, default: '0};

	// Long start wait must still fit inside the access window
	if (mpe_pkg::START_CYC >= mpe_pkg::ACC_CYC) begin : g_chk
		$error("start delay exceeds access window");
	end

	mpe_hstate_t s_q;
	mpe_hstate_t s_d;
	logic        line_s;
	logic        rise;
	logic [19:0] half;
	logic [19:0] gate_len;
	logic [19:0] smp_len;

	mpe_sync #(.INIT(1'b1)) u_line (
		.clk (clk),
		.srst(srst),
		.din (lnk.line),
		.dout(line_s)
	);

	assign rise = line_s & ~s_q.lv;
	assign half = 20'(half_cyc);
	assign gate_len = 20'(mpe_pkg::GATE_CYC)
		+ ((mode == mpe_pkg::OM_PWM) ? half : 20'h0);
	assign smp_len = (s_q.nb == 7'h1) ? (half + (half >> 1)) : (half << 1);

	always_comb begin
		s_d = s_q;
		s_d.lv = line_s;
		s_d.rx_v = 1'b0;
		s_d.rdy = 1'b0;
		s_d.cnt = s_q.cnt + 20'h1;
		case (s_q.st)
			H_IDLE: begin
				s_d.oe = 1'b0;
				s_d.pe = 1'b0;
				s_d.sh = frame;
				s_d.len = frame_len;
				s_d.rd = (kind == mpe_pkg::CMD_READ);
				s_d.cnt = 20'h0;
				s_d.pre = 16'h0;
				s_d.units = 9'h0;
				if (go_3w) begin
					s_d.pe = 1'b1;
					s_d.oe = 1'b1;
					s_d.st = H_PRE;
				end else if (go_aux) begin
					if (mode == mpe_pkg::OM_SENT || mode == mpe_pkg::OM_TRIG_SENT)
						s_d.st = H_WIN;
					else begin
						s_d.st = H_HOLD;
						s_d.oe = 1'b1;
					end
				end
			end
			H_PRE: begin
				if (s_q.cnt == 20'(mpe_pkg::START_CYC) + (half << 2) - 20'h1) begin
					s_d.st = H_TX;
					s_d.cnt = 20'h0;
					s_d.nb = 7'h0;
				end
			end
			H_WIN: begin
				if (frame_window) begin
					s_d.st = H_HOLD;
					s_d.oe = 1'b1;
				end
			end
			H_HOLD: begin
				if (s_q.pre == unit_cyc - 16'h1) begin
					s_d.pre = 16'h0;
					s_d.units = s_q.units + 9'h1;
				end else begin
					s_d.pre = s_q.pre + 16'h1;
				end
				// One unit of margin covers prescaler phase
				if (s_q.units == mpe_pkg::hold_min(mode) + 9'h1) begin
					s_d.st = H_REL;
					s_d.oe = 1'b0;
					s_d.cnt = 20'h0;
				end
			end
			H_REL: begin
				if (s_q.cnt == 20'(mpe_pkg::GATE_CYC + mpe_pkg::RISE_CYC - 1)) begin
					s_d.st = H_GATE;
					s_d.oe = 1'b1;
					s_d.cnt = 20'h0;
				end
			end
			H_GATE: begin
				if (s_q.cnt == gate_len - 20'h1) begin
					s_d.st = H_TX;
					s_d.cnt = 20'h0;
					s_d.nb = 7'h0;
				end
			end
			H_TX: begin
				s_d.oe = ~(s_q.nb[0] ? ~s_q.sh[48] : s_q.sh[48]);
				if (s_q.cnt == half - 20'h1) begin
					s_d.cnt = 20'h0;
					s_d.nb = s_q.nb + 7'h1;
					if (s_q.nb[0])
						s_d.sh = {s_q.sh[47:0], 1'b0};
					if (s_q.nb == {s_q.len - 6'h1, 1'b1}) begin
						s_d.oe = 1'b0;
						s_d.nb = 7'h0;
						s_d.st = s_q.rd ? H_RX : H_RDY;
					end
				end
			end
			H_RX: begin
				if (s_q.nb == 7'h0) begin
					// Own release edge arrives early, the answer much later
					if (rise && s_q.cnt > half) begin
						s_d.nb = 7'h1;
						s_d.cnt = 20'h0;
					end else if (s_q.cnt == 20'hFFFFF) begin
						s_d.st = H_RDY;
					end
				end else if (s_q.cnt == smp_len - 20'h1) begin
					s_d.cnt = 20'h0;
					s_d.rx_w = {s_q.rx_w[34:0], line_s};
					s_d.nb = s_q.nb + 7'h1;
					if (s_q.nb == 7'(mpe_pkg::RX_BITS)) begin
						s_d.rx_v = 1'b1;
						s_d.st = H_RDY;
					end
				end
			end
			H_RDY: begin
				s_d.rdy = 1'b1;
				s_d.sh = frame;
				s_d.len = frame_len;
				s_d.rd = (kind == mpe_pkg::CMD_READ);
				s_d.cnt = 20'h0;
				s_d.nb = 7'h0;
				if (end_prog) begin
					s_d.st = H_IDLE;
					s_d.pe = 1'b0;
					s_d.rdy = 1'b0;
				end else if (send) begin
					s_d.st = H_TX;
					s_d.rdy = 1'b0;
				end
			end
			default: s_d = H_RST;
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s_q <= H_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign lnk.program_enable = s_q.pe;
	assign lnk.host_oe = s_q.oe;
	assign lnk.host_out = 1'b0;
	assign ready = s_q.rdy;
	assign rx_valid = s_q.rx_v;
	assign rx_word = s_q.rx_w;
endmodule // mpe_host
`default_nettype wire

// File: src/mpe_dev.sv
// Functional notes
// - Program enable: stop driving, pin becomes input
// - Host holds line low two bits first
// - On enable removal re-enable output after delay
// - Up to four dies share one line
// - Four transaction kinds supported
// - Host waits start delay before signalling
// - PWM interrupt pulse accepted at any phase
// - PWM hold is two PWM periods minimum
// - After hold, device registers the rising edge
// - PWM: host drives gate plus half bit low
// - PWM: no access edge in time, abort
// - Host pulses only within SENT frame
// - SENT hold is at least thirty ticks
// - SENT: release, then gate low before code
// - SENT: no access edge in time, abort
// - Three-wire access code within power-on window
// - EEPROM write: delay, then high-to-low edge
// - Read answer uses host's bit rate
// - Falling edge means one, rising zero
`timescale 1ns/10ps
`default_nettype none
module mpe_dev #(
	parameter int unsigned DIE       = 0,
	parameter int unsigned MSGRX_MAX = mpe_pkg::MSGRX_MAX_CYC,
	parameter int unsigned WRITE_DLY = mpe_pkg::WRITE_CYC
) (
	input  wire logic               clk,
	input  wire logic               srst,
	mpe_if.dev                      lnk,
	input  wire mpe_pkg::mpe_mode_t mode,
	input  wire logic [15:0]        unit_cyc,
	input  wire logic               sense_lvl,
	input  wire logic               cmd_go,
	input  wire mpe_pkg::mpe_cmd_t  cmd_kind,
	input  wire logic [36:0]        resp_word,
	input  wire logic               leave_prog,
	output var  logic               rx_valid,
	output var  logic               rx_bit,
	output var  logic               rx_end,
	output var  logic               in_prog
);
	typedef enum logic [7:0] {
		D_NORM = 8'h01, D_REL = 8'h02, D_WAIT = 8'h04, D_RX = 8'h08,
		D_CMD = 8'h10, D_TX = 8'h20, D_EEW = 8'h40, D_OE = 8'h80
	} mpe_dst_t;

	typedef struct packed {
		mpe_dst_t    st;
		logic [19:0] cnt;
		logic [15:0] pre;
		logic [8:0]  units;
		logic [15:0] per;
		logic [6:0]  nb;
		logic [36:0] sh;
		logic        prog;
		logic        lv;
		logic        pe_lv;
		logic        oe;
		logic        po;
		logic        rx_v;
		logic        rx_b;
		logic        rx_e;
		logic        inp;
	} mpe_dstate_t;

	localparam mpe_dstate_t D_RST = '{st: D_NORM, lv: 1'b1, default: '0};

	if (DIE >= mpe_pkg::MAX_DIES) begin : g_chk_die
		$error("DIE index beyond shared line capacity");
	end
	if (MSGRX_MAX <= mpe_pkg::MSGRX_MIN_CYC || MSGRX_MAX > 20'hFFFFE)
	begin : g_chk_rx
		$error("MSGRX_MAX out of range");
	end
	if (WRITE_DLY < 1 || WRITE_DLY > 20'hFFFFF) begin : g_chk_wr
		$error("WRITE_DLY out of range");
	end

	mpe_dstate_t s_q;
	mpe_dstate_t s_d;
	logic        line_s;
	logic        pe_s;
	logic        rise;
	logic        fall;
	logic [19:0] per20;
	logic [19:0] half;

	mpe_sync #(.INIT(1'b1)) u_line (
		.clk (clk),
		.srst(srst),
		.din (lnk.line),
		.dout(line_s)
	);

	mpe_sync #(.INIT(1'b0)) u_pe (
		.clk (clk),
		.srst(srst),
		.din (lnk.program_enable),
		.dout(pe_s)
	);

	assign rise = line_s & ~s_q.lv;
	assign fall = ~line_s & s_q.lv;
	assign per20 = 20'(s_q.per);
	assign half = per20 >> 1;

	always_comb begin
		s_d = s_q;
		s_d.lv = line_s;
		s_d.pe_lv = pe_s;
		s_d.rx_v = 1'b0;
		s_d.rx_e = 1'b0;
		s_d.cnt = s_q.cnt + 20'h1;
		if (line_s) begin
			s_d.pre = 16'h0;
			s_d.units = 9'h0;
		end else if (s_q.pre == unit_cyc - 16'h1) begin
			s_d.pre = 16'h0;
			if (s_q.units != 9'h1FF)
				s_d.units = s_q.units + 9'h1;
		end else begin
			s_d.pre = s_q.pre + 16'h1;
		end
		case (s_q.st)
			D_NORM: begin
				s_d.oe = ~sense_lvl;
				s_d.prog = 1'b0;
				if (!line_s && s_q.units >= mpe_pkg::hold_min(mode)) begin
					// Own low phases never reach the threshold
					s_d.st = D_REL;
					s_d.oe = 1'b0;
				end
			end
			D_REL: begin
				s_d.oe = 1'b0;
				if (rise) begin
					s_d.cnt = 20'h0;
					if (s_q.units <= mpe_pkg::hold_max(mode))
						s_d.st = D_WAIT;
					else
						s_d.st = D_NORM;
				end
			end
			D_WAIT: begin
				s_d.oe = 1'b0;
				if (rise && (s_q.prog ||
					s_q.cnt >= 20'(mpe_pkg::MSGRX_MIN_CYC))) begin
					s_d.st = D_RX;
					s_d.cnt = 20'h0;
					s_d.per = 16'h0;
				end else if (!s_q.prog && s_q.cnt >= 20'(MSGRX_MAX)) begin
					s_d.st = D_NORM;
				end
			end
			D_RX: begin
				s_d.oe = 1'b0;
				if (rise && s_q.per == 16'h0) begin
					// Two sync zeros: mid-cell rises are one bit apart
					// Edge spacing is the count plus one
					s_d.per = s_q.cnt[15:0] + 16'h1;
					s_d.cnt = 20'h0;
				end else if ((rise || fall) && s_q.per != 16'h0 &&
					s_q.cnt >= per20 - (per20 >> 2)) begin
					s_d.rx_v = 1'b1;
					s_d.rx_b = fall;
					s_d.cnt = 20'h0;
				end else if (s_q.per != 16'h0 &&
					s_q.cnt > per20 + (per20 >> 1)) begin
					s_d.rx_e = 1'b1;
					s_d.st = D_CMD;
				end else if (s_q.per == 16'h0 && s_q.cnt >= 20'(MSGRX_MAX)) begin
					s_d.st = D_CMD;
				end
			end
			D_CMD: begin
				s_d.oe = 1'b0;
				s_d.cnt = 20'h0;
				s_d.nb = 7'h0;
				s_d.sh = resp_word;
				if (rise) begin
					s_d.st = D_RX;
					s_d.per = 16'h0;
				end else if (cmd_go) begin
					case (cmd_kind)
						mpe_pkg::CMD_READ: s_d.st = D_TX;
						mpe_pkg::CMD_WR_EEPROM: s_d.st = D_EEW;
						default: s_d.st = D_CMD;
					endcase
				end else if (leave_prog && !s_q.prog) begin
					s_d.st = D_OE;
				end
			end
			D_TX: begin
				s_d.oe = ~(s_q.nb[0] ? ~s_q.sh[36] : s_q.sh[36]);
				if (s_q.cnt == half - 20'h1) begin
					s_d.cnt = 20'h0;
					s_d.nb = s_q.nb + 7'h1;
					if (s_q.nb[0])
						s_d.sh = {s_q.sh[35:0], 1'b0};
					if (s_q.nb == 7'(2 * mpe_pkg::RESP_BITS - 1)) begin
						s_d.oe = 1'b0;
						s_d.st = D_CMD;
					end
				end
			end
			D_EEW: begin
				if (s_q.nb == 7'h0) begin
					s_d.oe = 1'b0;
					if (s_q.cnt == 20'(WRITE_DLY - 1)) begin
						s_d.nb = 7'h1;
						s_d.cnt = 20'h0;
						s_d.oe = 1'b1;
					end
				end else if (s_q.cnt >= per20 - 20'h1) begin
					s_d.oe = 1'b0;
					s_d.st = D_CMD;
				end
			end
			D_OE: begin
				s_d.oe = 1'b0;
				if (s_q.cnt == 20'(mpe_pkg::OE_CYC - 1))
					s_d.st = D_NORM;
			end
			default: s_d = D_RST;
		endcase
		if (pe_s && !s_q.pe_lv) begin
			s_d.st = D_WAIT;
			s_d.prog = 1'b1;
			s_d.oe = 1'b0;
			s_d.cnt = 20'h0;
		end else if (!pe_s && s_q.pe_lv) begin
			s_d.st = D_OE;
			s_d.prog = 1'b0;
			s_d.oe = 1'b0;
			s_d.cnt = 20'h0;
		end
		s_d.inp = (s_d.st != D_NORM);
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s_q <= D_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign lnk.dev_oe[DIE] = s_q.oe;
	assign lnk.dev_out[DIE] = s_q.po;
	assign rx_valid = s_q.rx_v;
	assign rx_bit = s_q.rx_b;
	assign rx_end = s_q.rx_e;
	assign in_prog = s_q.inp;
endmodule // mpe_dev
`default_nettype wire

// File: tb/mpe_props.sv
`timescale 1ns/10ps
`default_nettype none
module mpe_props #(
	parameter int HALF = 100
) (
	input wire logic                        clk,
	input wire logic                        srst,
	input wire logic                        program_enable,
	input wire logic                        host_out,
	input wire logic                        host_oe,
	input wire logic [mpe_pkg::MAX_DIES-1:0] dev_out,
	input wire logic [mpe_pkg::MAX_DIES-1:0] dev_oe,
	input wire logic                        line
);
	typedef struct packed {
		logic [15:0] pe;
		logic [15:0] lo;
		logic [15:0] hi;
		logic [15:0] dv;
		logic        seen;
	} mpe_chk_t;
	mpe_chk_t st_q;
	mpe_chk_t st_d;

	// Saturate so long idle spans never wrap into short ones
	function automatic logic [15:0] sat(logic [15:0] x);
		return (&x) ? x : x + 16'h0001;
	endfunction

	always_comb begin
		st_d = st_q;
		st_d.pe = program_enable ? sat(st_q.pe) : 16'h0000;
		st_d.lo = host_oe ? sat(st_q.lo) : 16'h0000;
		st_d.hi = host_oe ? 16'h0000 : sat(st_q.hi);
		st_d.dv = (|dev_oe) ? sat(st_q.dv) : 16'h0000;
		st_d.seen = program_enable & (st_q.seen | (~host_oe & (|st_q.lo)));
	end

	always_ff @(posedge clk) begin
		st_q <= srst ? '0 : st_d;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	sequence s_quiet;
		(dev_oe == '0) [*8];
	endsequence
	sequence s_first_fall;
		$fell(host_oe) && program_enable && !st_q.seen;
	endsequence

	chk_pe_release: assert property (
		$rose(program_enable) |-> ##6 s_quiet)
		else $error("die drives line under program enable");
	chk_pre_low: assert property (
		s_first_fall |-> st_q.lo >= 4 * HALF)
		else $error("host pre-frame low too short");
	chk_start_wait: assert property (
		s_first_fall |-> st_q.pe >= mpe_pkg::START_CYC)
		else $error("host signalling before start delay");
	chk_pe_restore: assert property (
		$fell(program_enable) |=> s_quiet)
		else $error("die drives right after program enable drop");
	chk_one_die: assert property (
		$onehot0(dev_oe))
		else $error("several dies drive the line");
	chk_release_len: assert property (
		$rose(host_oe) |-> st_q.hi >= mpe_pkg::GATE_CYC)
		else $error("host release shorter than gate time");
	chk_low_len: assert property (
		$fell(host_oe) |-> st_q.lo >= mpe_pkg::GATE_CYC)
		else $error("host low phase shorter than gate time");
	chk_answer_cells: assert property (
		$fell(|dev_oe) && program_enable |-> st_q.dv inside
			{[HALF-4:HALF+4], [2*HALF-4:2*HALF+4]})
		else $error("die answer cell off host bit rate");
	chk_host_cells: assert property (
		$fell(host_oe) && st_q.seen |-> st_q.lo inside
			{[HALF-2:HALF+2], [2*HALF-2:2*HALF+2]})
		else $error("host cell not half or whole bit");
endmodule // mpe_props
`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
	fails++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
`define WAIT(c, n, nm) begin wi = 0; while (!(c) && wi < n) begin \
	@(negedge clk); wi++; end `CHK(nm, 1'b1, 1'(c)) end
module tb;
	logic                clk, srst, go_3w, go_aux, send, end_prog;
	logic                h_ready, h_rxv, b_oe, b_inp, fwin, b_sense;
	logic [35:0]         h_rxw;
	logic [48:0]         frame, f;
	logic [5:0]          flen;
	logic [15:0]         unit, b_unit, half;
	logic [3:0]          cmd_go, leave, d_rxv, d_rxb, d_end, d_inp, sense;
	logic [36:0]         resp;
	mpe_pkg::mpe_mode_t  mode, b_mode;
	mpe_pkg::mpe_cmd_t   kind, ck;
	mpe_pkg::mpe_cmd_t   kinds[3] = '{mpe_pkg::CMD_WR_VOLATILE,
		mpe_pkg::CMD_WR_EEPROM, mpe_pkg::CMD_READ};
	logic                q[$];
	int                  fails, comparisons, wi, k, len;

	mpe_if lnk ();
	mpe_if lnk_b ();
	// Second link: the bench plays a host that never sends a code
	assign lnk_b.program_enable = 1'b0;
	assign lnk_b.host_out = 1'b0;
	assign lnk_b.host_oe = b_oe;
	assign lnk_b.dev_oe[3:1] = 3'h0;
	assign lnk_b.dev_out[3:1] = 3'h0;

	mpe_host mpe_host_i (.clk, .srst, .lnk(lnk.host), .mode,
		.unit_cyc(unit), .half_cyc(half), .frame_window(fwin),
		.go_3w, .go_aux, .send, .kind, .frame, .frame_len(flen),
		.end_prog, .ready(h_ready), .rx_valid(h_rxv), .rx_word(h_rxw));
	for (genvar g = 0; g < 4; g++) begin : g_die
		mpe_dev #(.DIE(g), .MSGRX_MAX(600), .WRITE_DLY(200)) mpe_dev_i (
			.clk, .srst, .lnk(lnk.dev), .mode, .unit_cyc(unit),
			.sense_lvl(sense[g]), .cmd_go(cmd_go[g]), .cmd_kind(ck),
			.resp_word(resp), .leave_prog(leave[g]), .rx_valid(d_rxv[g]),
			.rx_bit(d_rxb[g]), .rx_end(d_end[g]), .in_prog(d_inp[g]));
	end
	mpe_dev #(.MSGRX_MAX(600), .WRITE_DLY(200)) mpe_dev_i (.clk, .srst,
		.lnk(lnk_b.dev), .mode(b_mode), .unit_cyc(b_unit), .sense_lvl(b_sense),
		.cmd_go(cmd_go[0]), .cmd_kind(ck), .resp_word(resp),
		.leave_prog(leave[0]), .rx_valid(), .rx_bit(), .rx_end(),
		.in_prog(b_inp));
	mpe_props #(.HALF(100)) mpe_props_i (.clk, .srst,
		.program_enable(lnk.program_enable), .host_out(lnk.host_out),
		.host_oe(lnk.host_oe), .dev_out(lnk.dev_out),
		.dev_oe(lnk.dev_oe), .line(lnk.line));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	always @(negedge clk) if (d_rxv[0] === 1'b1) q.push_back(d_rxb[0]);

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic check_rx(input logic [48:0] fr, input int n);
		`CHK("rx_count", n - 2, q.size())
		for (int i = 0; i < n - 2 && i < q.size(); i++)
			`CHK("rx_bit", fr[46-i], q[i])
		q = {};
	endtask

	// Output comes back only after the enable delay has run
	task automatic check_restore;
		cyc(mpe_pkg::OE_CYC - 10);
		`CHK("in_prog_hold", 4'hF, d_inp)
		`WAIT(d_inp === 4'h0, 30, "in_prog_clear")
	endtask

	task automatic print_verdict;
		if (fails == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		#4500000;
		fails++;
		print_verdict();
	end

	initial begin
		srst = 1'b1; go_3w = 1'b0; go_aux = 1'b0; send = 1'b0;
		end_prog = 1'b0; kind = mpe_pkg::CMD_WR_ACCESS; ck = kind;
		frame = '0; flen = '0; mode = mpe_pkg::OM_PWM; unit = 16'h0028;
		cmd_go = 4'h0; leave = 4'h0; b_oe = 1'b0; b_mode = mode;
		b_unit = unit; resp = {2'b00, 32'h5A3C_C3A5, 3'h6};
		fails = 0; comparisons = 0;
		half = 16'h0064; fwin = 1'b1; sense = 4'hF; b_sense = 1'b1;
		cyc(4);
		srst = 1'b0;
		cyc(20);
		// Die 0 alone pulls the shared line in normal output
		sense = 4'hE;
		cyc(2);
		`CHK("sense_drive", 1'b0, lnk.line)
		sense = 4'hF;
		cyc(20);
		// Two-wire entry over PWM, then a write access frame
		f = {2'b00, 1'b0, 4'h1, 7'h00, 32'hC3A5_5A3C, 3'h5};
		frame = f; flen = 6'd49; go_aux = 1'b1;
		cyc(1);
		go_aux = 1'b0;
		`WAIT(d_end[0], 20000, "aux_rx_end")
		`CHK("aux_in_prog", 4'hF, d_inp)
		check_rx(f, 49);
		cmd_go = 4'hF;
		cyc(1);
		cmd_go = 4'h0;
		`WAIT(h_ready, 100, "aux_ready")
		end_prog = 1'b1; leave = 4'hF;
		cyc(1);
		end_prog = 1'b0; leave = 4'h0;
		check_restore();
		cyc(50);
		// Three-wire: the remaining kinds, each aimed at its own die
		for (int i = 0; i < 3; i++) begin
			k = i + 1;
			f = {2'b00, 1'(i == 2), 4'(1 << k), 7'(8'h40 + i),
				32'h5A5A_0000 + i, 3'h3};
			len = (i == 2) ? 17 : 49;
			if (i == 2)
				f = {f[48:35], f[2:0], 32'h0};
			frame = f; flen = 6'(len); kind = kinds[i];
			if (i == 0)
				go_3w = 1'b1;
			else
				send = 1'b1;
			cyc(1);
			go_3w = 1'b0; send = 1'b0;
			`WAIT(d_end[0], 60000, "pe_rx_end")
			check_rx(f, len);
			ck = kinds[i]; cmd_go[k] = 1'b1;
			cyc(1);
			cmd_go = 4'h0;
			if (i == 1) begin
				wi = 0;
				while (lnk.dev_oe[k] !== 1'b1 && wi < 400) begin
					@(negedge clk);
					wi++;
				end
				`CHK("eeprom_dly", 1'b1, 1'(wi >= 195 && wi <= 210))
			end
			if (i == 2) begin
				`WAIT(h_rxv, 20000, "read_valid")
				`CHK("read_word", resp[35:0], h_rxw)
			end
			`WAIT(h_ready, 20000, "pe_ready")
			// Answers and done pulses look like frames to the other dies
			cyc(7000);
			q = {};
		end
		end_prog = 1'b1;
		cyc(1);
		end_prog = 1'b0;
		check_restore();
		// Entry thresholds and abort with no access code
		for (int i = 0; i < 4; i++) begin
			b_mode = (i < 2) ? mpe_pkg::OM_PWM : mpe_pkg::OM_SENT;
			b_unit = (i < 2) ? 16'h0028 : 16'h0004;
			b_oe = 1'b1;
			cyc((i == 0) ? 50 : (i == 1) ? 120 : (i == 2) ? 116 : 128);
			b_oe = 1'b0;
			cyc(8);
			`CHK("b_entry", 1'(i % 2), b_inp)
			`WAIT(b_inp === 1'b0, 700, "b_abort")
			cyc(50);
		end
		print_verdict();
	end
endmodule // tb
`default_nettype wire
